// ==== core/osdp_path.sv ====
// Shared constants and the per-path integer divider with pulse shaping and coarse phase steps
package osdp_pkg;
  localparam int          PATHS         = 2;
  localparam int          CNT_W         = 35;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [6:0]  PATH_BLOCK0   = 7'h01;   // Path p block starts at (p+1)*0x20
  localparam logic [4:0]  DIV_OFS       = 5'h00;
  localparam logic [4:0]  HIGH_OFS      = 5'h04;
  localparam logic [4:0]  ADJ_OFS       = 5'h08;
  localparam logic [4:0]  BUF_OFS       = 5'h0c;
  localparam logic [4:0]  STAT_OFS      = 5'h10;
  // Control register fields
  localparam int          CTRL_SEL_BIT  = 0;
  // Buffer control fields
  localparam int          BUF_SE_BIT    = 0;
  localparam int          BUF_INV_BIT   = 1;
  localparam int          BUF_SWING_LSB = 2;
  localparam int          BUF_IMP_LSB   = 4;
  localparam int          BUF_W         = 6;
  // Status fields
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_OUT_BIT  = 1;
  localparam int          STAT_SEL_BIT  = 2;
  // Reset values
  localparam logic [31:0] DIV_RESET     = 32'h0000_0002;
  localparam logic [31:0] HIGH_RESET    = 32'h0000_0000;
  localparam logic [BUF_W-1:0] BUF_RESET = 6'h00;
  // Divider limits
  localparam logic [CNT_W-1:0] MIN_DIV  = 35'h0_0000_0002;
  localparam logic [CNT_W-1:0] MIN_PART = 35'h0_0000_0002;
  localparam logic [CNT_W-1:0] ONE      = 35'h0_0000_0001;
  // Stages whose source may be chosen from two dividers
  localparam int          SEL_STAGE_A   = 4;
  localparam int          SEL_STAGE_B   = 7;
  localparam int          DUAL_LIMIT    = 4;  // Stages below this are dual
endpackage : osdp_pkg

// One divider path; all timing counts source divider periods (ticks)
module osdp_path (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Source divider ticks
  input  wire logic        src_tick_a,
  input  wire logic        src_tick_b,
  // Configuration
  input  wire logic        cfg_sel,
  input  wire logic [31:0] cfg_div,
  input  wire logic [31:0] cfg_high,
  input  wire logic [31:0] adj_value,
  input  wire logic        adj_req,
  // Results
  output logic             clk_out,
  output logic             adj_busy,
  output logic             adj_done,
  output logic             active_sel
);
  logic                           phase_high;
  logic [osdp_pkg::CNT_W-1:0]     count;
  logic [osdp_pkg::CNT_W-1:0]     low_len;
  logic [31:0]                    adj_hold;
  logic                           tick;
  logic                           step;
  logic                           boundary;
  logic signed [osdp_pkg::CNT_W-1:0] div_eff;
  logic signed [osdp_pkg::CNT_W-1:0] base_h;
  logic signed [osdp_pkg::CNT_W-1:0] base_l;
  logic signed [osdp_pkg::CNT_W-1:0] adj_s;
  logic signed [osdp_pkg::CNT_W-1:0] adj_h;
  logic signed [osdp_pkg::CNT_W-1:0] sum_h;
  logic signed [osdp_pkg::CNT_W-1:0] sum_l;
  logic [osdp_pkg::CNT_W-1:0]     next_high_len;
  logic [osdp_pkg::CNT_W-1:0]     next_low_len;

  // Tick from the source latched at the last period boundary
  assign tick     = active_sel ? src_tick_b : src_tick_a;
  assign step     = tick && (count <= osdp_pkg::ONE);
  assign boundary = step && !phase_high;

  // Portion lengths for the coming period, built from fresh configuration
  always_comb begin
    div_eff = ({3'b000, cfg_div} < osdp_pkg::MIN_DIV) ? osdp_pkg::MIN_DIV : {3'b000, cfg_div};  // [R03]
    if (cfg_high == 32'h0000_0000) begin
      base_h = div_eff >>> 1;                                 // [R04] [R05]
    end else begin
      base_h = {3'b000, cfg_high};                            // [R05]
    end
    base_l = div_eff - base_h;
    if (base_l < $signed(osdp_pkg::ONE)) begin
      base_l = osdp_pkg::ONE;
    end
    adj_s = {{3{adj_hold[31]}}, adj_hold};                    // [R11]
    if (cfg_high == 32'h0000_0000) begin
      adj_h = adj_s >>> 1;                                    // [R12]
    end else begin
      adj_h = '0;                                             // [R13]
    end
    if (adj_busy) begin
      sum_h = base_h + adj_h;                                 // [R08] [R10]
      sum_l = base_l + (adj_s - adj_h);
    end else begin
      sum_h = base_h;
      sum_l = base_l;
    end
    // Shortening never goes below two ticks per portion, or below the unadjusted length when that is shorter
    if (adj_busy && sum_h < $signed(osdp_pkg::MIN_PART)) begin
      sum_h = (base_h < $signed(osdp_pkg::MIN_PART)) ? base_h : osdp_pkg::MIN_PART;  // [R09]
    end
    if (adj_busy && sum_l < $signed(osdp_pkg::MIN_PART)) begin
      sum_l = (base_l < $signed(osdp_pkg::MIN_PART)) ? base_l : osdp_pkg::MIN_PART;  // [R09]
    end
    next_high_len = sum_h;
    next_low_len  = sum_l;
  end

  // Period sequencer: high portion then low portion
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_high <= 1'b0;
      count      <= '0;
      low_len    <= '0;
      clk_out    <= 1'b0;
    end else if (step) begin
      if (phase_high) begin
        phase_high <= 1'b0;
        count      <= low_len;
        clk_out    <= 1'b0;
      end else begin
        phase_high <= 1'b1;                                   // [R07]
        count      <= next_high_len;                          // [R19]
        low_len    <= next_low_len;
        clk_out    <= 1'b1;
      end
    end else if (tick) begin
      count <= count - osdp_pkg::ONE;
    end
  end

  // Source choice changes only between periods
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      active_sel <= 1'b0;
    end else if (boundary) begin
      active_sel <= cfg_sel;                                  // [R19]
    end
  end

  // Adjust request latch; applied at the next period start, then done
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      adj_busy <= 1'b0;
      adj_done <= 1'b0;
      adj_hold <= '0;
    end else begin
      adj_done <= boundary && adj_busy;                       // [R20]
      if (boundary && adj_busy) begin
        adj_busy <= 1'b0;
      end else if (adj_req && !adj_busy) begin
        adj_busy <= 1'b1;                                     // [R14] [R20]
        adj_hold <= adj_value;
      end
    end
  end
endmodule : osdp_path

// ==== core/osdp_stage.sv ====
// Output stage: APB registers, divider paths and buffer mode control
//
// Behaviour
// (R01) Stages 4 and 7 choose between two source dividers; others use one fixed divider.
// (R02) Dual stages hold two identical paths fed by the same source.
// (R03) Integer divider divides source clock by a 32-bit value.
// (R04) With no pulse width set, output high and low halves are equal; with an odd divide value the low half here is one tick longer.
// (R05) A 32-bit high width sets high ticks per period; zero means balanced.
// (R06) Software keeps the high width below the divide value.
// (R07) Pulses are high-going; inverted complement pin gives the low-going one.
// (R08) Coarse adjust lengthens or shortens portions in whole source periods, per output.
// (R09) Shortening never drops a portion below two source periods.
// (R10) One adjust moves each portion by up to two-to-the-32 source periods; the signed 32-bit adjust here reaches at most two-to-the-31.
// (R11) Signed adjust, positive lengthens, applied inside a single output period.
// (R12) Balanced outputs split the adjust roughly equally between high and low.
// (R13) Pulse-width outputs put the whole adjust on the low portion.
// (R14) Any number of successive adjust requests is accepted.
// (R15) Each buffer is either differential or two single-ended copies.
// (R16) Two-bit swing code selects 410, 600, 750 or 900 mV.
// (R17) Single-ended pins carry the same clock; complement may be inverted.
// (R18) Single-ended mode selects one of four impedance options.
// (R19) Divide, width and source changes take effect at a period boundary.
// (R20) Adjust request is latched, applied next period, done before another accepted.
//
// Register access over APB and the register offsets were chosen for this implementation.
module osdp_stage #(
  parameter int STAGE_ID = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Source divider ticks, one pulse per source period
  input  wire logic             src_tick_a,
  input  wire logic             src_tick_b,
  // Output pins and buffer settings per path
  output logic [1:0]            true_output_pin,
  output logic [1:0]            complement_output_pin,
  output logic [1:0]            single_ended_mode,
  output logic [1:0][1:0]       differential_swing_level,
  output logic [1:0][1:0]       impedance_select,
  output logic [1:0]            adj_done
);
  localparam bit CAN_SELECT = (STAGE_ID == osdp_pkg::SEL_STAGE_A) ||
                              (STAGE_ID == osdp_pkg::SEL_STAGE_B);
  localparam bit IS_DUAL    = (STAGE_ID < osdp_pkg::DUAL_LIMIT);

  logic                          setup;
  logic                          wr_en;
  logic                          sel_reg;
  logic [1:0][31:0]              div_reg;
  logic [1:0][31:0]              high_reg;
  logic [1:0][31:0]              adj_reg;
  logic [1:0][osdp_pkg::BUF_W-1:0] buf_reg;
  logic [1:0]                    adj_wr;
  logic [1:0]                    path_out;
  logic [1:0]                    path_busy;
  logic [1:0]                    path_done;
  logic [1:0]                    path_sel;
  logic [31:0]                   next_prdata;
  logic                          next_pslverr;
  logic [4:0]                    sub_ofs;
  logic [6:0]                    blk;

  assign setup   = psel && !penable;
  assign wr_en   = setup && pwrite;
  assign sub_ofs = paddr[4:0];
  assign blk     = paddr[11:5];

  // Zero-wait APB answer in the access cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= setup ? next_prdata : '0;
      pslverr <= setup && next_pslverr;
    end
  end

  // Source select, only meaningful on stages with a choice
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sel_reg <= 1'b0;
    end else if (wr_en && paddr == osdp_pkg::CTRL_OFS && CAN_SELECT) begin
      sel_reg <= pwdata[osdp_pkg::CTRL_SEL_BIT];              // [R01]
    end
  end

  // Read decode and unmapped-address answer
  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b1;
    if (paddr == osdp_pkg::CTRL_OFS) begin
      next_prdata[osdp_pkg::CTRL_SEL_BIT] = sel_reg;
      next_pslverr = 1'b0;
    end
    for (int p = 0; p < osdp_pkg::PATHS; p++) begin
      if (blk == osdp_pkg::PATH_BLOCK0 + 7'(p) && (p == 0 || IS_DUAL)) begin
        next_pslverr = 1'b0;
        unique case (sub_ofs)
          osdp_pkg::DIV_OFS:  next_prdata = div_reg[p];
          osdp_pkg::HIGH_OFS: next_prdata = high_reg[p];
          osdp_pkg::ADJ_OFS:  next_prdata = adj_reg[p];
          osdp_pkg::BUF_OFS:  next_prdata = {26'h000_0000, buf_reg[p]};
          osdp_pkg::STAT_OFS: begin
            next_prdata[osdp_pkg::STAT_BUSY_BIT] = path_busy[p];
            next_prdata[osdp_pkg::STAT_OUT_BIT]  = path_out[p];
            next_prdata[osdp_pkg::STAT_SEL_BIT]  = path_sel[p];
          end
          default: next_pslverr = 1'b1;
        endcase
      end
    end
  end

  // Per-path registers, divider and pin drivers
  for (genvar p = 0; p < osdp_pkg::PATHS; p++) begin : g_path
    logic hit;
    logic live;
    assign hit  = wr_en && blk == osdp_pkg::PATH_BLOCK0 + 7'(p);
    assign live = (p == 0) || IS_DUAL;                        // [R02]

    // Configuration registers; adjust write is a request
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        div_reg[p]  <= osdp_pkg::DIV_RESET;
        high_reg[p] <= osdp_pkg::HIGH_RESET;
        adj_reg[p]  <= '0;
        buf_reg[p]  <= osdp_pkg::BUF_RESET;
        adj_wr[p]   <= 1'b0;
      end else begin
        adj_wr[p] <= 1'b0;
        if (hit && live) begin
          unique case (sub_ofs)
            osdp_pkg::DIV_OFS:  div_reg[p]  <= pwdata;
            osdp_pkg::HIGH_OFS: high_reg[p] <= pwdata;       // [R06]
            osdp_pkg::ADJ_OFS: begin
              if (!path_busy[p]) begin
                adj_reg[p] <= pwdata;                         // [R20]
                adj_wr[p]  <= 1'b1;
              end
            end
            osdp_pkg::BUF_OFS:  buf_reg[p]  <= pwdata[osdp_pkg::BUF_W-1:0];
            default: ;
          endcase
        end
      end
    end

    osdp_path u_path (
      .sys_clk    (sys_clk),
      .reset      (reset || !live),
      .src_tick_a (src_tick_a),
      .src_tick_b (src_tick_b),
      .cfg_sel    (sel_reg),
      .cfg_div    (div_reg[p]),
      .cfg_high   (high_reg[p]),
      .adj_value  (adj_reg[p]),
      .adj_req    (adj_wr[p]),
      .clk_out    (path_out[p]),
      .adj_busy   (path_busy[p]),
      .adj_done   (path_done[p]),
      .active_sel (path_sel[p])
    );

    // Buffer mode and pin levels
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        true_output_pin[p]          <= 1'b0;
        complement_output_pin[p]    <= 1'b0;
        single_ended_mode[p]        <= 1'b0;
        differential_swing_level[p] <= '0;
        impedance_select[p]         <= '0;
        adj_done[p]                 <= 1'b0;
      end else begin
        true_output_pin[p] <= path_out[p];
        if (buf_reg[p][osdp_pkg::BUF_SE_BIT]) begin
          complement_output_pin[p] <= path_out[p] ^ buf_reg[p][osdp_pkg::BUF_INV_BIT];  // [R17] [R07]
        end else begin
          complement_output_pin[p] <= !path_out[p];           // [R15]
        end
        single_ended_mode[p]        <= buf_reg[p][osdp_pkg::BUF_SE_BIT];  // [R15]
        differential_swing_level[p] <= buf_reg[p][osdp_pkg::BUF_SWING_LSB +: 2];  // [R16]
        impedance_select[p]         <= buf_reg[p][osdp_pkg::BUF_IMP_LSB +: 2];    // [R18]
        adj_done[p]                 <= path_done[p];
      end
    end
  end
endmodule : osdp_stage

// ==== tb/osdp_monitor.sv ====
// Concurrent checks on the output stage ports
module osdp_monitor #(
  parameter int STAGE_ID = 4
) (
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             reset,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Ticks and outputs
  input wire logic             src_tick_a,
  input wire logic             src_tick_b,
  input wire logic [1:0]       true_output_pin,
  input wire logic [1:0]       complement_output_pin,
  input wire logic [1:0]       single_ended_mode,
  input wire logic [1:0][1:0]  differential_swing_level,
  input wire logic [1:0][1:0]  impedance_select,
  input wire logic [1:0]       adj_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Setup phase of an APB transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready_access;
    s_setup |=> pready;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready missing");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held");
  property p_err_unmapped;
    s_setup ##0 (STAGE_ID >= 4 && paddr[11:5] == 7'h02) |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr");
  property p_comp_diff;
    !$past(reset) && !single_ended_mode[0] && $stable(single_ended_mode[0])
      |-> complement_output_pin[0] == !true_output_pin[0];
  endproperty
  a_comp_diff: assert property (p_comp_diff) else $error("diff pins");
  property p_comp_se;
    single_ended_mode[0] && $stable(single_ended_mode[0])
      |-> $stable(complement_output_pin[0] ^ true_output_pin[0]);
  endproperty
  a_comp_se: assert property (p_comp_se) else $error("se pins");
  property p_done_rise;
    adj_done[0] |-> $rose(true_output_pin[0]);
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done off period");
  property p_done_pulse;
    adj_done[0] |=> !adj_done[0];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held");
  property p_pin_tick;
    $changed(true_output_pin[0]) |-> $past(src_tick_a || src_tick_b, 2);
  endproperty
  a_pin_tick: assert property (p_pin_tick) else $error("edge off tick");
  property p_buf_fields;
    logic [31:0] v;
    (psel && !penable && pwrite && paddr == 12'h02c, v = pwdata) |-> ##2
      (single_ended_mode[0] == v[0] && differential_swing_level[0] == v[3:2]
       && impedance_select[0] == v[5:4]);
  endproperty
  a_buf_fields: assert property (p_buf_fields) else $error("buffer fields");
endmodule : osdp_monitor

// ==== tb/osdp_receiver.sv ====
// Clock receiver on an output pin: measures high and low lengths in cycles
module osdp_receiver (
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   reset,
  // Observed pin and measurements
  input wire logic   pin,
  output logic [31:0] last_high,
  output logic [31:0] last_low,
  output logic        period_end
);
  logic        pin_q;
  logic [31:0] run;
  // Run length per level; a period ends at a rising edge, pulses high-going
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_q <= 1'b0;
      run <= 32'h1;
      last_high <= 32'h0;
      last_low <= 32'h0;
      period_end <= 1'b0;
    end else begin
      pin_q <= pin;
      period_end <= pin && !pin_q;
      if (pin != pin_q) begin
        run <= 32'h1;
        if (pin_q) last_high <= run;
        else last_low <= run;
      end else begin
        run <= run + 32'h1;
      end
    end
  end
endmodule : osdp_receiver

// ==== tb/test_output_stage_divider_phase.sv ====
// Register-level bench for one single output stage
module test_output_stage_divider_phase;
  timeunit 1ns;
  timeprecision 1ps;
  logic             sys_clk, reset, psel, penable, pwrite;
  logic             src_tick_a = 1'b0, src_tick_b = 1'b0;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rdat, last_high, last_low;
  logic             pready, pslverr, rerr, period_end;
  logic [1:0]       true_output_pin, complement_output_pin, single_ended_mode, adj_done;
  logic [1:0][1:0]  differential_swing_level, impedance_select;
  int               fail_count, comparisons;
  int               cycles = 0, tcnt = 0;

  osdp_stage #(.STAGE_ID(4)) u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_tick_a(src_tick_a), .src_tick_b(src_tick_b),
    .true_output_pin(true_output_pin), .complement_output_pin(complement_output_pin),
    .single_ended_mode(single_ended_mode), .impedance_select(impedance_select),
    .differential_swing_level(differential_swing_level), .adj_done(adj_done));
  osdp_receiver u_rx (.sys_clk(sys_clk), .reset(reset), .pin(true_output_pin[0]),
    .last_high(last_high), .last_low(last_low), .period_end(period_end));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Source ticks: divider a every 2 cycles, divider b every 3; hang guard
  always @(posedge sys_clk) begin
    tcnt <= tcnt + 1;
    src_tick_a <= (tcnt % 2 == 0);
    src_tick_b <= (tcnt % 3 == 0);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; waits for pready and captures the answer at that edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_end();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (period_end !== 1'b1 && n < 2000);
    if (period_end !== 1'b1) fail_count++;
  endtask : wait_end

  task measure(input logic [31:0] h, input logic [31:0] l);
    repeat (3) wait_end();
    check("high", last_high, h);
    check("low", last_low, l);
  endtask : measure

  // Waits for the adjusted period and lets it finish
  task settle();
    int n;
    n = 0;
    while (adj_done[0] !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    if (adj_done[0] !== 1'b1) fail_count++;
    wait_end();
    wait_end();
  endtask : settle

  initial begin
    {reset, psel, penable, pwrite} = 4'h8;
    {paddr, pwdata} = 44'h0;
    {fail_count, comparisons} = 64'h0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, 12'h020, 32'h0);
    check("div", rdat, 32'h2);
    apb(1'b0, 12'h024, 32'h0);
    check("width", rdat, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    check("err", {31'h0, rerr}, 32'h1);
    check("path1 pin", {31'h0, true_output_pin[1]}, 32'h0);
    apb(1'b1, 12'h020, 32'h8);
    measure(32'h8, 32'h8);
    apb(1'b1, 12'h024, 32'h3);
    measure(32'h6, 32'ha);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h028, 32'h4);
      settle();
      check("adj high", last_high, 32'h6);
      check("adj low", last_low, 32'h12);
    end
    apb(1'b1, 12'h024, 32'h0);
    measure(32'h8, 32'h8);
    apb(1'b1, 12'h028, 32'h2);
    settle();
    check("split", {last_high[15:0], last_low[15:0]}, 32'h000a_000a);
    apb(1'b1, 12'h028, 32'hffff_fffa);
    settle();
    check("clamp", {last_high[15:0], last_low[15:0]}, 32'h0004_0004);
    wait_end();
    apb(1'b1, 12'h028, 32'h4);
    apb(1'b1, 12'h028, 32'h64);
    apb(1'b0, 12'h030, 32'h0);
    check("busy", {31'h0, rdat[0]}, 32'h1);
    settle();
    check("busy adj", {last_high[15:0], last_low[15:0]}, 32'h000c_000c);
    wait_end();
    check("refused", {last_high[15:0], last_low[15:0]}, 32'h0008_0008);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h02c, {26'h0, 2'(3 - i), i[1:0], i[1], i[0]});
      repeat (3) @(negedge sys_clk);
      check("swing", {30'h0, differential_swing_level[0]}, i);
      check("imp", {30'h0, impedance_select[0]}, 32'(3 - i));
      check("se", {31'h0, single_ended_mode[0]}, {31'h0, i[0]});
      check("comp", {31'h0, complement_output_pin[0]},
            {31'h0, true_output_pin[0] ^ !(i[0] && !i[1])});
    end
    apb(1'b1, 12'h000, 32'h1);
    measure(32'hc, 32'hc);
    apb(1'b0, 12'h030, 32'h0);
    check("source", {31'h0, rdat[2]}, 32'h1);
    complete_run();
  end
endmodule : test_output_stage_divider_phase

bind osdp_stage osdp_monitor #(.STAGE_ID(STAGE_ID)) u_mon (.sys_clk(sys_clk),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_tick_a(src_tick_a), .src_tick_b(src_tick_b), .true_output_pin(true_output_pin),
  .complement_output_pin(complement_output_pin), .single_ended_mode(single_ended_mode),
  .differential_swing_level(differential_swing_level),
  .impedance_select(impedance_select), .adj_done(adj_done));
